// >>> inc/cmp_pkg.sv
// Package with constants and types of the CAN mode and power control block
package cmp_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] CMP_CTRL_OFS = 4'h0;
  localparam logic [3:0] CMP_STAT_OFS = 4'h1;
  localparam logic [3:0] CMP_TXE_OFS = 4'h2;
  localparam logic [3:0] CMP_WAKE_OFS = 4'h3;
  localparam logic [3:0] CMP_BTR_OFS = 4'h4;
  localparam logic [3:0] CMP_RIER_OFS = 4'h5;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CMP_CTRL_INIT_REQUEST = 0;
  localparam int CMP_CTRL_SLEEP_REQUEST = 1;
  localparam int CMP_CTRL_WAKE_ENABLE = 2;
  localparam int CMP_CTRL_STOP_IN_WAIT_BIT = 3;
  localparam int CMP_CTRL_LISTEN = 4;
  localparam int CMP_CTRL_WAKE_FILTER_MODE = 5;
  localparam int CMP_CTRL_MODULE_ENABLE_BIT = 6;
  localparam int CMP_CTRL_WAKE_IRQ_ENABLE = 7;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] CMP_CTRL_RST = 8'h01;
  localparam logic [2:0] CMP_TXE_RST = 3'h7;
  localparam logic [7:0] CMP_BTR_RST = 8'h00;
  localparam logic [7:0] CMP_RIER_RST = 8'h00;
  localparam int CMP_SYNC_DELAY = 2;
  localparam int CMP_IDLE_BITS = 11;
  localparam int CMP_BOFF_SEQS = 128;
  localparam int CMP_RECOVERY_CYCLES = 16;
  localparam int CMP_FILTER_CYCLES = 8;
  localparam int CMP_BIT_CYCLES = 10;

  typedef enum logic [2:0] {
    CMP_NORMAL,
    CMP_SLEEP,
    CMP_INIT,
    CMP_PDOWN,
    CMP_RECOVER,
    CMP_RESYNC
  } cmp_mode_t;

endpackage : cmp_pkg

// >>> inc/cmp_sync_if.sv
// Interface carrying the CAN-side mode handshake
`timescale 1ns/1ns
interface cmp_sync_if;
  logic init_req;
  logic init_ack;
  modport ctrl (output init_req, input init_ack);
  modport engine (input init_req, output init_ack);
endinterface : cmp_sync_if

// >>> logic/cmp_init_sync.sv
// Init request synchroniser standing in for the CAN clock side
`timescale 1ns/1ns
module cmp_init_sync (
  input wire logic clk,
  input wire logic rst,
  cmp_sync_if.engine sif
);
  import cmp_pkg::*;

  logic [2:0] can_q;
  logic [1:0] back_q;

  // ****************************************
  // Request through three stages, answer back through two
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      can_q <= 3'h0;
      back_q <= 2'h0;
    end else begin
      can_q <= {can_q[1:0], sif.init_req};
      back_q <= {back_q[0], can_q[2]};
    end
  end

  assign sif.init_ack = back_q[1] & sif.init_req;

endmodule : cmp_init_sync

// >>> logic/cmp_mode_ctrl.sv
// CAN mode and power control top module
`timescale 1ns/1ns
module cmp_mode_ctrl #(
  parameter int TX_BUFS = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic cpu_stop,
  input wire logic cpu_wait,
  input wire logic can_rx_pin,
  output logic can_tx_pin,
  input wire logic eng_tx_bit,
  input wire logic eng_tx_start,
  input wire logic eng_tx_done,
  input wire logic eng_rx_busy,
  input wire logic eng_rx_frame_ok,
  input wire logic eng_bus_off,
  input wire logic eng_boff_seq,
  output logic eng_rx_bit,
  output logic eng_run,
  output logic eng_abort,
  output logic eng_rx_copy_en,
  output logic eng_tx_abort_en,
  output logic eng_boff_count_en,
  output logic eng_synced,
  output logic regs_clk_en,
  output logic wake_irq
);
  import cmp_pkg::*;

  cmp_sync_if sif ();

  logic [1:0] rx_sync_q;
  logic rx_s;
  logic init_rq_q, slp_rq_q, wake_enable_q, stop_in_wait_bit_q, listen_q, wake_filter_mode_q, module_enable_bit_q, wake_irq_enable_q;
  logic module_enable_bit_set_q;
  logic slp_ak_q, wake_irq_flag_q;
  logic [TX_BUFS-1:0] txe_q;
  logic [7:0] btr_q, rier_q, boff_cnt_q;
  cmp_mode_t mode_q, mode_d;
  logic slept_q;
  logic [1:0] sync_cnt_q;
  logic [4:0] rec_cnt_q;
  logic [3:0] bit_cnt_q, rec_bits_q;
  logic [3:0] filt_cnt_q;
  logic pdown, access_ok, rx_masked, wake_evt, rx_gated, init_ak;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ****************************************
  // Pin synchroniser
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sync_q <= 2'h3;
    end else begin
      rx_sync_q <= {rx_sync_q[0], can_rx_pin};
    end
  end
  assign rx_s = rx_sync_q[1];

  // ****************************************
  // Init handshake across domains
  // ****************************************
  assign sif.init_req = init_rq_q;
  cmp_init_sync u_sync (
    .clk(clk),
    .rst(rst),
    .sif(sif)
  );
  assign init_ak = sif.init_ack;

  // ****************************************
  // Power-down decode
  // ****************************************
  assign pdown = module_enable_bit_q & (cpu_stop | (cpu_wait & stop_in_wait_bit_q));
  assign access_ok = ~pdown;

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {wake_irq_enable_q, module_enable_bit_q, wake_filter_mode_q, listen_q, stop_in_wait_bit_q, wake_enable_q, slp_rq_q, init_rq_q} <= CMP_CTRL_RST;
      module_enable_bit_set_q <= 1'b0;
    end else if (wr && access_ok && hit(addr, CMP_CTRL_OFS)) begin
      if (!module_enable_bit_set_q) begin
        module_enable_bit_q <= wdata[CMP_CTRL_MODULE_ENABLE_BIT];
        module_enable_bit_set_q <= 1'b1;
      end
      if (wdata[CMP_CTRL_INIT_REQUEST] || init_ak) begin
        init_rq_q <= wdata[CMP_CTRL_INIT_REQUEST];
      end
      if (wdata[CMP_CTRL_SLEEP_REQUEST] || slp_ak_q) begin
        slp_rq_q <= wdata[CMP_CTRL_SLEEP_REQUEST] & ~init_rq_q;
      end
      wake_enable_q <= wdata[CMP_CTRL_WAKE_ENABLE];
      stop_in_wait_bit_q <= wdata[CMP_CTRL_STOP_IN_WAIT_BIT];
      wake_irq_enable_q <= wdata[CMP_CTRL_WAKE_IRQ_ENABLE];
      if (init_ak) begin
        listen_q <= wdata[CMP_CTRL_LISTEN];
        wake_filter_mode_q <= wdata[CMP_CTRL_WAKE_FILTER_MODE];
      end
    end else if (mode_q == CMP_SLEEP && wake_evt) begin
      slp_rq_q <= 1'b0;
    end else if (init_ak) begin
      slp_rq_q <= 1'b0;
      wake_enable_q <= 1'b0;
    end
  end

  // ****************************************
  // Transmit buffer empty flags
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txe_q <= CMP_TXE_RST[TX_BUFS-1:0];
    end else if (init_ak) begin
      txe_q <= CMP_TXE_RST[TX_BUFS-1:0];
    end else begin
      if (wr && access_ok && hit(addr, CMP_TXE_OFS)) begin
        txe_q <= txe_q & ~wdata[TX_BUFS-1:0];
      end else if (eng_tx_done) begin
        txe_q <= txe_q | (txe_q + 1'b1);
      end
    end
  end

  // ****************************************
  // Config and enable registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btr_q <= CMP_BTR_RST;
      rier_q <= CMP_RIER_RST;
    end else begin
      if (wr && access_ok && init_ak && hit(addr, CMP_BTR_OFS)) begin
        btr_q <= wdata;
      end
      if (init_ak) begin
        rier_q <= CMP_RIER_RST;
      end else if (wr && access_ok && hit(addr, CMP_RIER_OFS)) begin
        rier_q <= wdata;
      end
    end
  end

  // ****************************************
  // Wake filter and wake event
  // ****************************************
  assign rx_masked = (mode_q == CMP_SLEEP) ? (rx_s | ~wake_enable_q) : rx_s;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_cnt_q <= 4'h0;
    end else if (rx_masked || mode_q != CMP_SLEEP) begin
      filt_cnt_q <= 4'h0;
    end else if (filt_cnt_q != 4'(CMP_FILTER_CYCLES)) begin
      filt_cnt_q <= filt_cnt_q + 4'h1;
    end
  end
  assign wake_evt = (mode_q == CMP_SLEEP) && wake_enable_q &&
                    (wake_filter_mode_q ? (filt_cnt_q == 4'(CMP_FILTER_CYCLES)) : ~rx_masked);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_irq_flag_q <= 1'b0;
    end else if (wake_evt) begin
      wake_irq_flag_q <= 1'b1;
    end else if (wr && access_ok && hit(addr, CMP_WAKE_OFS) && wdata[0]) begin
      wake_irq_flag_q <= 1'b0;
    end
  end
  assign wake_irq = wake_irq_flag_q & wake_irq_enable_q & wake_enable_q;

  // ****************************************
  // Mode machine
  // ****************************************
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      CMP_NORMAL: begin
        if (pdown) begin
          mode_d = CMP_PDOWN;
        end else if (init_ak) begin
          mode_d = CMP_INIT;
        end else if (slp_rq_q && &txe_q && !eng_rx_busy &&
                     sync_cnt_q == 2'(CMP_SYNC_DELAY)) begin
          mode_d = CMP_SLEEP;
        end
      end
      CMP_SLEEP: begin
        if (pdown) begin
          mode_d = CMP_PDOWN;
        end else if (init_ak) begin
          mode_d = CMP_INIT;
        end else if (wake_evt || !slp_rq_q) begin
          mode_d = CMP_RESYNC;
        end
      end
      CMP_INIT: begin
        if (!init_rq_q) begin
          mode_d = CMP_RESYNC;
        end
      end
      CMP_PDOWN: begin
        if (!pdown) begin
          mode_d = slept_q ? CMP_SLEEP : CMP_RECOVER;
        end
      end
      CMP_RECOVER: begin
        if (rec_cnt_q == 5'(CMP_RECOVERY_CYCLES)) begin
          mode_d = CMP_RESYNC;
        end
      end
      CMP_RESYNC: begin
        if (pdown) begin
          mode_d = CMP_PDOWN;
        end else if (rec_bits_q == 4'(CMP_IDLE_BITS)) begin
          mode_d = CMP_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= CMP_NORMAL;
      slept_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      if (mode_q != CMP_PDOWN) begin
        slept_q <= (mode_q == CMP_SLEEP);
      end
    end
  end

  // ****************************************
  // Sleep acknowledge and sync delay
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slp_ak_q <= 1'b0;
      sync_cnt_q <= 2'h0;
    end else begin
      slp_ak_q <= (mode_d == CMP_SLEEP) && slp_rq_q;
      if (!slp_rq_q || mode_q != CMP_NORMAL) begin
        sync_cnt_q <= 2'h0;
      end else if (sync_cnt_q != 2'(CMP_SYNC_DELAY)) begin
        sync_cnt_q <= sync_cnt_q + 2'h1;
      end
    end
  end

  // ****************************************
  // Recovery and resync counters
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rec_cnt_q <= 5'h0;
      bit_cnt_q <= 4'h0;
      rec_bits_q <= 4'h0;
    end else begin
      rec_cnt_q <= (mode_q == CMP_RECOVER) ? rec_cnt_q + 5'h1 : 5'h0;
      if (mode_q != CMP_RESYNC || !rx_s) begin
        bit_cnt_q <= 4'h0;
        rec_bits_q <= 4'h0;
      end else if (bit_cnt_q == 4'(CMP_BIT_CYCLES - 1)) begin
        bit_cnt_q <= 4'h0;
        if (rec_bits_q != 4'(CMP_IDLE_BITS)) begin
          rec_bits_q <= rec_bits_q + 4'h1;
        end
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end

  // ****************************************
  // Bus-off recovery count
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boff_cnt_q <= 8'h00;
    end else if (!eng_bus_off) begin
      boff_cnt_q <= 8'h00;
    end else if (eng_boff_count_en && eng_boff_seq &&
                 boff_cnt_q != 8'(CMP_BOFF_SEQS)) begin
      boff_cnt_q <= boff_cnt_q + 8'h01;
    end
  end

  // ****************************************
  // Engine and pin outputs
  // ****************************************
  always_comb begin
    eng_run = module_enable_bit_q && (mode_q == CMP_NORMAL);
    regs_clk_en = module_enable_bit_q && !pdown;
    eng_abort = (mode_q == CMP_INIT) || (mode_q == CMP_PDOWN) || pdown || init_ak;
    eng_rx_copy_en = eng_run;
    eng_tx_abort_en = eng_run;
    eng_boff_count_en = eng_run;
    eng_synced = eng_run && !eng_abort;
    can_tx_pin = (eng_run && !eng_abort && !listen_q) ? eng_tx_bit : 1'b1;
    eng_rx_bit = (listen_q && !eng_tx_bit) ? 1'b0 : rx_masked;
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd && access_ok) begin
      unique case (addr)
        CMP_CTRL_OFS: rdata <= {wake_irq_enable_q, module_enable_bit_q, wake_filter_mode_q, listen_q, stop_in_wait_bit_q, wake_enable_q, slp_rq_q,
                                init_rq_q};
        CMP_STAT_OFS: rdata <= {3'h0, eng_rx_frame_ok, eng_tx_start & eng_run & ~listen_q,
                                mode_q == CMP_NORMAL,
                                slp_ak_q, init_ak};
        CMP_TXE_OFS: rdata <= 8'(txe_q);
        CMP_WAKE_OFS: rdata <= {7'h00, wake_irq_flag_q};
        CMP_BTR_OFS: rdata <= btr_q;
        CMP_RIER_OFS: rdata <= rier_q;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : cmp_mode_ctrl

// >>> testbench/cmp_bus_model.sv
// Two-node CAN bus model seen through the transceiver
`timescale 1ns/1ns
module cmp_bus_model (
  input wire logic tx_pin,
  input wire logic node_dom,
  output logic rx_pin
);
  // Wired-AND: a dominant 0 from either node wins, recessive otherwise
  assign rx_pin = tx_pin & ~node_dom;
endmodule : cmp_bus_model

// >>> testbench/cmp_mode_asserts.sv
// Port checker of the CAN mode and power control block
`timescale 1ns/1ns
module cmp_mode_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic cpu_stop,
  input wire logic can_tx_pin,
  input wire logic eng_run,
  input wire logic eng_rx_copy_en,
  input wire logic eng_tx_abort_en,
  input wire logic eng_boff_count_en,
  input wire logic regs_clk_en,
  input wire logic wake_irq
);
  import cmp_pkg::*;
  logic module_enable_bit_q;
  logic stat_rd_q;
  wire logic asleep = stat_rd_q & rdata[1];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Snooped module enable and status reads
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      module_enable_bit_q <= 1'b0;
    end else if (wr && addr == CMP_CTRL_OFS && wdata[CMP_CTRL_MODULE_ENABLE_BIT]) begin
      module_enable_bit_q <= 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_rd_q <= 1'b0;
    end else begin
      stat_rd_q <= rd && addr == CMP_STAT_OFS;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_disabled_halt: assert property (!module_enable_bit_q |-> !eng_run)
    else $error("engine runs while disabled");
  a_idle_recessive: assert property (!eng_run |-> can_tx_pin)
    else $error("transmit pin dominant while engine stopped");
  a_stop_pdown: assert property (module_enable_bit_q && cpu_stop && $past(cpu_stop) |->
    can_tx_pin && !eng_run && !regs_clk_en) else $error("stop did not power down");
  a_pdown_refuse: assert property (module_enable_bit_q && cpu_stop && $past(cpu_stop) && rd
    |=> rdata == 8'h00) else $error("register read in power-down");
  a_sleep_gates: assert property (asleep |-> regs_clk_en && !eng_run)
    else $error("sleep clock gating wrong");
  a_sleep_blocks: assert property (asleep |-> !eng_rx_copy_en && !eng_tx_abort_en)
    else $error("receive copy or abort enabled in sleep");
  a_sleep_boff: assert property (asleep |-> !eng_boff_count_en && can_tx_pin)
    else $error("bus-off count or transmit active in sleep");
  a_wake_origin: assert property ($rose(wake_irq) |-> !$past(eng_run))
    else $error("wake interrupt raised outside sleep");
  c_asleep: cover property (asleep);
  c_wake: cover property ($rose(wake_irq));
  c_pdown_read: cover property (module_enable_bit_q && cpu_stop && rd);
endmodule : cmp_mode_asserts

bind cmp_mode_ctrl cmp_mode_asserts u_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .cpu_stop(cpu_stop), .can_tx_pin(can_tx_pin), .eng_run(eng_run),
  .eng_rx_copy_en(eng_rx_copy_en), .eng_tx_abort_en(eng_tx_abort_en),
  .eng_boff_count_en(eng_boff_count_en), .regs_clk_en(regs_clk_en), .wake_irq(wake_irq)
);

// >>> testbench/tb.sv
// Self-checking testbench of the CAN mode and power control block
`timescale 1ns/1ns
module tb;
  import cmp_pkg::*;
  logic clk, rst, wr, rd, cpu_stop, cpu_wait, node_dom;
  logic eng_tx_bit, eng_tx_start, eng_tx_done, eng_rx_busy;
  logic [3:0] addr;
  logic [7:0] wdata;
  wire logic [7:0] rdata;
  wire logic can_rx_pin, can_tx_pin, eng_rx_bit, wake_irq;
  int bad_count = 0;
  int compares = 0;
  cmp_mode_ctrl dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait), .can_rx_pin(can_rx_pin),
    .can_tx_pin(can_tx_pin), .eng_tx_bit(eng_tx_bit), .eng_tx_start(eng_tx_start),
    .eng_tx_done(eng_tx_done), .eng_rx_busy(eng_rx_busy), .eng_rx_frame_ok(1'b0),
    .eng_bus_off(1'b0), .eng_boff_seq(1'b0), .eng_rx_bit(eng_rx_bit), .eng_run(),
    .eng_abort(), .eng_rx_copy_en(), .eng_tx_abort_en(), .eng_boff_count_en(),
    .eng_synced(), .regs_clk_en(), .wake_irq(wake_irq));
  cmp_bus_model bus (.tx_pin(can_tx_pin), .node_dom(node_dom), .rx_pin(can_rx_pin));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string n);
    logic [7:0] v;
    rd_reg(a, v);
    check(n, e, v & m);
  endtask : rd_chk
  task automatic poll(input logic [7:0] m, input logic [7:0] e, input string n);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 200 && (v & m) !== e; i++) begin
      rd_reg(CMP_STAT_OFS, v);
    end
    check(n, e, v & m);
  endtask : poll
  task automatic done(input string n);
    $display("Test %s finished", n);
  endtask : done
  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    {wr, rd, cpu_stop, cpu_wait, node_dom, eng_tx_start, eng_tx_done, eng_rx_busy} = 8'h00;
    eng_tx_bit = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(CMP_CTRL_OFS, 8'hFF, CMP_CTRL_RST, "ctrl_reset");
    wr_reg(CMP_CTRL_OFS, 8'h51);
    idle(10);
    rd_chk(CMP_STAT_OFS, 8'h01, 8'h01, "init_ack");
    wr_reg(CMP_BTR_OFS, 8'h5A);
    rd_chk(CMP_BTR_OFS, 8'hFF, 8'h5A, "btr_init_write");
    wr_reg(CMP_CTRL_OFS, 8'h50);
    poll(8'h04, 8'h04, "normal_listen");
    eng_tx_bit <= 1'b0;
    eng_tx_start <= 1'b1;
    idle(2);
    check("listen_tx_pin", 8'h01, {7'h00, can_tx_pin});
    check("listen_loopback", 8'h00, {7'h00, eng_rx_bit});
    rd_chk(CMP_STAT_OFS, 8'h08, 8'h00, "listen_no_start");
    eng_tx_start <= 1'b0;
    eng_tx_bit <= 1'b1;
    done("listen");
    wr_reg(CMP_RIER_OFS, 8'hFF);
    wr_reg(CMP_BTR_OFS, 8'h33);
    wr_reg(CMP_CTRL_OFS, 8'h41);
    rd_chk(CMP_STAT_OFS, 8'h01, 8'h00, "init_ack_early");
    wr_reg(CMP_CTRL_OFS, 8'h40);
    idle(8);
    rd_chk(CMP_STAT_OFS, 8'h01, 8'h01, "init_hold");
    rd_chk(CMP_RIER_OFS, 8'hFF, 8'h00, "rier_cleared");
    rd_chk(CMP_BTR_OFS, 8'hFF, 8'h5A, "btr_locked");
    wr_reg(CMP_CTRL_OFS, 8'h40);
    poll(8'h04, 8'h04, "normal");
    eng_tx_bit <= 1'b0;
    idle(2);
    check("tx_pin_drive", 8'h00, {7'h00, can_tx_pin});
    eng_tx_bit <= 1'b1;
    done("init");
    wr_reg(CMP_TXE_OFS, 8'h01);
    eng_rx_busy <= 1'b1;
    wr_reg(CMP_CTRL_OFS, 8'hC6);
    idle(20);
    rd_chk(CMP_STAT_OFS, 8'h02, 8'h00, "sleep_wait_tx");
    eng_tx_done <= 1'b1;
    @(posedge clk);
    eng_tx_done <= 1'b0;
    idle(20);
    rd_chk(CMP_TXE_OFS, 8'h07, 8'h07, "tx_all_empty");
    rd_chk(CMP_STAT_OFS, 8'h02, 8'h00, "sleep_wait_rx");
    eng_rx_busy <= 1'b0;
    poll(8'h02, 8'h02, "sleep_ack");
    rd_chk(CMP_CTRL_OFS, 8'h02, 8'h02, "sleep_req_set");
    node_dom <= 1'b1;
    idle(20);
    node_dom <= 1'b0;
    idle(40);
    check("wake_irq", 8'h01, {7'h00, wake_irq});
    rd_chk(CMP_WAKE_OFS, 8'h01, 8'h01, "wake_flag");
    rd_chk(CMP_STAT_OFS, 8'h04, 8'h00, "resync_wait");
    idle(60);
    poll(8'h04, 8'h04, "resync_done");
    wr_reg(CMP_WAKE_OFS, 8'h01);
    @(posedge clk);
    check("wake_irq_clear", 8'h00, {7'h00, wake_irq});
    done("sleep_wake");
    wr_reg(CMP_CTRL_OFS, 8'hC2);
    poll(8'h02, 8'h02, "sleep_ack_locked");
    node_dom <= 1'b1;
    idle(20);
    node_dom <= 1'b0;
    idle(10);
    rd_chk(CMP_WAKE_OFS, 8'h01, 8'h00, "no_wake_flag");
    rd_chk(CMP_STAT_OFS, 8'h02, 8'h02, "sleep_locked");
    wr_reg(CMP_CTRL_OFS, 8'h40);
    poll(8'h04, 8'h04, "wake_by_cpu");
    eng_rx_busy <= 1'b1;
    wr_reg(CMP_CTRL_OFS, 8'hC2);
    wr_reg(CMP_CTRL_OFS, 8'h40);
    rd_chk(CMP_CTRL_OFS, 8'h02, 8'h02, "sleep_request_held");
    eng_rx_busy <= 1'b0;
    poll(8'h02, 8'h02, "sleep_ack_late");
    wr_reg(CMP_CTRL_OFS, 8'h40);
    poll(8'h04, 8'h04, "wake_again");
    done("sleep_lock");
    cpu_stop <= 1'b1;
    eng_tx_bit <= 1'b0;
    idle(3);
    check("pdown_tx", 8'h01, {7'h00, can_tx_pin});
    rd_chk(CMP_CTRL_OFS, 8'hFF, 8'h00, "pdown_read");
    cpu_stop <= 1'b0;
    eng_tx_bit <= 1'b1;
    @(posedge clk);
    rd_chk(CMP_STAT_OFS, 8'h04, 8'h00, "recovery");
    poll(8'h04, 8'h04, "recovered");
    wr_reg(CMP_CTRL_OFS, 8'h48);
    cpu_wait <= 1'b1;
    idle(3);
    rd_chk(CMP_CTRL_OFS, 8'hFF, 8'h00, "wait_pdown");
    cpu_wait <= 1'b0;
    poll(8'h04, 8'h04, "wait_recovered");
    wr_reg(CMP_CTRL_OFS, 8'h40);
    cpu_wait <= 1'b1;
    idle(3);
    rd_chk(CMP_CTRL_OFS, 8'hFF, 8'h40, "wait_running");
    cpu_wait <= 1'b0;
    done("power_down");
    tally_and_finish();
  end
endmodule : tb
